//--- inc/tms_ifs.sv
// Purpose: carriers between the scan core and its two helpers
// Assumes: one clock domain
// Notes:   burst carrier also holds the registered pin drives

`timescale 1ns/1ps

interface tms_burst_if;
	logic              start;
	logic              done;
	logic              strobe;
	logic [6:0]        len;
	logic [2:0]        row;
	logic [2:0]        col;
	logic [7:0]        offset;
	logic [1:0]        cz;
	logic [7:0]        x_drive;
	logic [7:0]        y_gate;
	logic [2:0]        mux_sel;
	logic              gate;
	logic              integ_rst;
	logic [1:0]        cancel_cap;
	modport ctl (output start, len, row, col, offset, cz,
		input done, strobe, x_drive, y_gate, mux_sel, gate, integ_rst, cancel_cap);
	modport gen (input start, len, row, col, offset, cz,
		output done, strobe, x_drive, y_gate, mux_sel, gate, integ_rst, cancel_cap);
endinterface

interface tms_sup_if;
	logic              start;
	logic              done;
	logic [5:0]        idx;
	logic signed [8:0] dev;
	logic              en;
	logic signed [8:0] max_dev;
	modport ctl (output start, dev, en, input done, idx, max_dev);
	modport sup (input start, dev, en, output done, idx, max_dev);
endinterface

//--- inc/tms_pkg.sv
// Purpose: shared constants and types of the touch-matrix scan logic
// Assumes: 20 MHz core clock
// Notes:   timing counts are derived from times in their own units

package tms_pkg;

	// ****************************************
	// matrix geometry and clock
	// ****************************************
	localparam int          CLK_MHZ      = 20;
	localparam int          NKEYS        = 64;
	localparam int          KEY_W        = 6;

	// ****************************************
	// timing
	// ****************************************
	localparam int          DWELL_NS        = 167;
	localparam int          DWELL_CYC       = (DWELL_NS * CLK_MHZ + 999) / 1000;
	localparam int          SETTLE_US       = 8;
	localparam int          SETTLE_CYC      = SETTLE_US * CLK_MHZ;
	localparam int          PULSE_SPACE_NS  = 2000;
	localparam int          PULSE_SPACE_CYC = PULSE_SPACE_NS * CLK_MHZ / 1000;
	localparam int          PULSE_HIGH_CYC  = PULSE_SPACE_CYC / 2;
	localparam int          PULSE_LOW_CYC   = PULSE_SPACE_CYC - PULSE_HIGH_CYC;
	localparam int          BURST_UNIT_US   = 250;
	localparam int          BURST_UNIT_CYC  = BURST_UNIT_US * CLK_MHZ;

	// ****************************************
	// calibration and reference window
	// ****************************************
	localparam logic [4:0]  FULL_CAL_BURSTS = 5'h1A;
	localparam logic [4:0]  CAL_OFF_STEPS   = 5'h08;
	localparam logic [4:0]  CAL_CZ_STEPS    = 5'h0A;
	localparam logic [7:0]  REF_HI_LIMIT    = 8'hBF;
	localparam logic [7:0]  REF_LO_LIMIT    = 8'h40;
	localparam logic [7:0]  ADC_MID         = 8'h80;
	localparam logic [7:0]  ADC_CZ_HIGH     = 8'hE0;
	localparam logic [7:0]  OFFSET_INIT     = 8'h80;
	localparam logic [7:0]  REF_INIT        = 8'h80;
	localparam logic [1:0]  CZ_MAX          = 2'h2;

	// ****************************************
	// setup defaults and variants
	// ****************************************
	localparam logic [6:0]  MAX_BURST       = 7'h40;
	localparam logic [6:0]  DEF_BURST       = 7'h10;
	localparam logic [1:0]  VAR_32          = 2'h0;
	localparam logic [1:0]  VAR_48          = 2'h1;
	localparam logic [6:0]  MAXK_32         = 7'h20;
	localparam logic [6:0]  MAXK_48         = 7'h30;
	localparam logic [6:0]  MAXK_64         = 7'h40;

	// ****************************************
	// status and error bit positions
	// ****************************************
	localparam int          ST_DET_BIT      = 0;
	localparam int          ST_CAL_BIT      = 1;
	localparam int          ST_ERR_BIT      = 2;
	localparam int          ST_NV_BIT       = 4;
	localparam int          ERR_HI_BIT      = 2;
	localparam int          ERR_LO_BIT      = 3;

	typedef enum logic [1:0] {
		SC_INIT = 2'b00,
		SC_SLOT = 2'b01,
		SC_SUP  = 2'b11
	} tms_scan_t;

	typedef enum logic [1:0] {
		BG_IDLE   = 2'b00,
		BG_LOW    = 2'b01,
		BG_HIGH   = 2'b11,
		BG_SETTLE = 2'b10
	} tms_burst_t;

endpackage

//--- rtl/tms_burst_gen.sv
// Purpose: one key's burst of X pulses, sampling gate, offset drive, ADC strobe
// Assumes: start only while idle
// Notes:   zero length returns done at once with no strobe

`timescale 1ns/1ps

module tms_burst_gen
	import tms_pkg::*;
(
	input  wire logic  clk,  // core clock
	input  wire logic  rst,  // sync reset
	tms_burst_if.gen   bi    // burst request and pin drives
);

	tms_burst_t  st_r;
	logic [7:0]  cnt_r;
	logic [6:0]  left_r;

	wire last_low   = (cnt_r == 8'(PULSE_LOW_CYC - 1));
	wire pre_rise   = (cnt_r == 8'(PULSE_LOW_CYC - 2));
	wire dwell_end  = (cnt_r == 8'(DWELL_CYC - 1));
	wire last_high  = (cnt_r == 8'(PULSE_HIGH_CYC - 1));
	wire settle_end = (cnt_r == 8'(SETTLE_CYC - 1));

	always_ff @(posedge clk) begin
		bi.done   <= 1'b0;
		bi.strobe <= 1'b0;
		if (rst) begin
			st_r          <= BG_IDLE;
			cnt_r         <= 8'h00;
			left_r        <= 7'h00;
			bi.x_drive    <= 8'h00;
			bi.y_gate     <= 8'h00;
			bi.mux_sel    <= 3'h0;
			bi.gate       <= 1'b0;
			bi.integ_rst  <= 1'b1;
			bi.cancel_cap <= 2'h0;
		end else begin
			cnt_r <= cnt_r + 8'h01;
			case (st_r)
				BG_IDLE: begin
					cnt_r <= 8'h00;
					if (bi.start && bi.len == 7'h00) begin
						bi.done <= 1'b1;
					end else if (bi.start) begin
						left_r        <= bi.len;
						bi.mux_sel    <= bi.col;
						bi.y_gate     <= 8'h01 << bi.col;
						bi.integ_rst  <= 1'b0;
						bi.cancel_cap <= {bi.cz == CZ_MAX, bi.cz != 2'h0};
						st_r          <= BG_LOW;
					end
				end
				BG_LOW: begin
					if (pre_rise)
						bi.gate <= 1'b1;
					if (last_low) begin
						bi.x_drive <= 8'h01 << bi.row;
						cnt_r      <= 8'h00;
						st_r       <= BG_HIGH;
					end
				end
				BG_HIGH: begin
					if (dwell_end)
						bi.gate <= 1'b0;
					if (last_high) begin
						cnt_r  <= 8'h00;
						left_r <= left_r - 7'h01;
						if (left_r == 7'h01) begin
							bi.x_drive <= bi.offset;
							st_r       <= BG_SETTLE;
						end else begin
							bi.x_drive <= 8'h00;
							st_r       <= BG_LOW;
						end
					end
				end
				BG_SETTLE: begin
					if (settle_end) begin
						bi.strobe     <= 1'b1;
						bi.done       <= 1'b1;
						bi.x_drive    <= 8'h00;
						bi.y_gate     <= 8'h00;
						bi.integ_rst  <= 1'b1;
						bi.cancel_cap <= 2'h0;
						st_r          <= BG_IDLE;
					end
				end
				default: st_r <= BG_IDLE;
			endcase
		end
	end

endmodule

//--- rtl/tms_scan_top.sv
// Purpose: key scan sequencing, calibration, suppression and status of a touch matrix
// Assumes: setup, command and ADC inputs synchronous to clk
// Notes:   nonvolatile store itself sits outside; only its handshakes live here

`timescale 1ns/1ps

module tms_scan_top
	import tms_pkg::*;
#(
	parameter int unsigned BURST_UNIT = BURST_UNIT_CYC
)(
	input  wire logic          clk,               // core clock
	input  wire logic          rst,               // hard reset, sync
	input  wire logic          soft_reset,        // soft reset pulse
	input  wire logic [1:0]    variant,           // key count strap
	input  wire logic          setup_valid,       // setup store passes check
	input  wire logic          nv_mismatch,       // store and backup differ
	input  wire logic          setup_wr,          // setup write pulse
	input  wire logic [5:0]    setup_key,         // key written
	input  wire logic [6:0]    setup_burst,       // burst length, 0 disables
	input  wire logic          setup_sup_en,      // suppression enable
	input  wire logic [2:0]    spacing_sel,       // burst spacing in 250 us units minus one
	input  wire logic [7:0]    det_threshold,     // negative detect threshold
	input  wire logic          recal_cmd,         // recalibrate pulse
	input  wire logic [63:0]   recal_scope,       // keys in command scope
	input  wire logic [63:0]   fast_recal,        // fast recalibration requests
	input  wire logic [63:0]   guard_fail,        // guardband failures per key
	input  wire logic [7:0]    adc_data,          // converted sample
	input  wire logic [5:0]    err_query_key,     // key for error byte
	output logic [7:0]         x_drive,           // X rows and ladder code
	output logic [7:0]         y_gate,            // one-hot column gate
	output logic [2:0]         column_mux_select, // analog mux select
	output logic               sample_gate,       // charge gate enable
	output logic               integ_reset,       // integrator reset
	output logic [1:0]         cancel_capacitor,  // cancel caps switched in
	output logic               adc_sample,        // ADC sample pulse
	output logic               backup_copy,       // copy setup to backup pulse
	output logic               backup_restore,    // restore setup pulse
	output logic [7:0]         status_byte,       // summary status
	output logic [63:0]        key_detect,        // detect bits
	output logic [63:0]        key_error,         // error bitfield
	output logic [7:0]         err_byte           // error byte of queried key
);

	// ****************************************
	// per-key state
	// ****************************************
	logic [6:0]        burst_m [NKEYS];
	logic              supen_m [NKEYS];
	logic [7:0]        ref_m   [NKEYS];
	logic [7:0]        sig_m   [NKEYS];
	logic [7:0]        off_m   [NKEYS];
	logic [1:0]        cz_m    [NKEYS];
	logic [4:0]        cal_m   [NKEYS];
	logic [63:0]       fr_r;
	logic signed [8:0] dev     [NKEYS];

	tms_scan_t         st_r;
	logic              hard_r;
	logic [1:0]        var_r;
	logic [6:0]        en_cnt_r;
	logic              dirty_r;
	logic [5:0]        key_r;
	logic [15:0]       slot_r;
	logic              bstart_r;
	logic [7:0]        status_r;
	logic [63:0]       det_r;
	logic [63:0]       err_r;
	logic [7:0]        errb_r;
	logic              bk_r;
	logic              rs_r;
	logic [63:0]       err_hi;
	logic [63:0]       err_lo;
	logic [63:0]       raw_det;
	logic [63:0]       det_nxt;
	logic [63:0]       cal_any;

	tms_burst_if bi();
	tms_sup_if   si();

	tms_burst_gen u_burst (
		.clk (clk),
		.rst (rst),
		.bi  (bi.gen)
	);

	tms_strength_sup u_sup (
		.clk (clk),
		.rst (rst),
		.si  (si.sup)
	);

	// ****************************************
	// decode
	// ****************************************
	wire [6:0]  max_keys  = (var_r == VAR_32) ? MAXK_32 : (var_r == VAR_48) ? MAXK_48 : MAXK_64;
	wire [6:0]  init_max  = (variant == VAR_32) ? MAXK_32 :
		(variant == VAR_48) ? MAXK_48 : MAXK_64;
	wire        wr_old_en = burst_m[setup_key] != 7'h00;
	wire        wr_new_en = setup_burst != 7'h00;
	wire        wr_over   = wr_new_en && !wr_old_en && en_cnt_r >= max_keys;
	wire        wr_ok     = setup_wr && st_r != SC_INIT && setup_burst <= MAX_BURST && !wr_over;
	wire [15:0] slot_len  = 16'(BURST_UNIT * ({29'h0, spacing_sel} + 32'h1));
	wire        slot_end  = slot_r == slot_len - 16'h0001;
	wire        scan_wrap = slot_end && key_r == 6'(NKEYS - 1);
	wire        smp       = bi.strobe;
	wire [4:0]  cal_k     = cal_m[key_r];
	wire [4:0]  cal_step  = FULL_CAL_BURSTS - cal_k;
	wire [2:0]  sar_bit   = 3'(7 - cal_step);
	wire        sar_keep  = adc_data >= ADC_MID;
	wire        init_go   = st_r == SC_INIT;

	// key index is {Y, X}: X advances first inside a column
	assign bi.start  = bstart_r;
	assign bi.len    = burst_m[key_r];
	assign bi.row    = key_r[2:0];
	assign bi.col    = key_r[5:3];
	assign bi.offset = off_m[key_r];
	assign bi.cz     = cz_m[key_r];
	assign si.start  = scan_wrap;
	assign si.dev    = dev[si.idx];
	assign si.en     = supen_m[si.idx] && burst_m[si.idx] != 7'h00;

	always_comb begin
		for (int k = 0; k < NKEYS; k++) begin
			dev[k]     = $signed({1'b0, ref_m[k]}) - $signed({1'b0, sig_m[k]});
			err_hi[k]  = ref_m[k] > REF_HI_LIMIT;
			err_lo[k]  = ref_m[k] < REF_LO_LIMIT;
			// a disabled key never samples, so it must not hold the calibrating flag up
			cal_any[k] = cal_m[k] != 5'h00 && burst_m[k] != 7'h00;
			raw_det[k] = burst_m[k] != 7'h00 && !cal_any[k] &&
				dev[k] >= $signed({1'b0, det_threshold});
			// a tie is not more negative, so both equal keys may detect
			det_nxt[k] = raw_det[k] && !(supen_m[k] && dev[k] < si.max_dev);
		end
	end

	// ****************************************
	// scan sequencing
	// ****************************************
	always_ff @(posedge clk) begin
		bstart_r <= 1'b0;
		bk_r     <= 1'b0;
		rs_r     <= 1'b0;
		if (rst) begin
			st_r   <= SC_INIT;
			hard_r <= 1'b1;
			var_r  <= VAR_32;
			key_r  <= 6'h00;
			slot_r <= 16'h0000;
		end else if (soft_reset) begin
			st_r <= SC_INIT;
		end else begin
			case (st_r)
				SC_INIT: begin
					if (hard_r)
						var_r <= variant;
					hard_r   <= 1'b0;
					bk_r     <= setup_valid;
					rs_r     <= !setup_valid;
					key_r    <= 6'h00;
					slot_r   <= 16'h0000;
					bstart_r <= 1'b1;
					st_r     <= SC_SLOT;
				end
				SC_SLOT, SC_SUP: begin
					slot_r <= slot_end ? 16'h0000 : slot_r + 16'h0001;
					if (slot_end) begin
						key_r    <= key_r + 6'h01;
						bstart_r <= 1'b1;
					end
					if (scan_wrap)
						st_r <= SC_SUP;
					else if (si.done)
						st_r <= SC_SLOT;
				end
				default: st_r <= SC_INIT;
			endcase
		end
	end

	// ****************************************
	// setup store and calibration state
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			en_cnt_r <= 7'h00;
			dirty_r  <= 1'b0;
			fr_r     <= 64'h0;
			for (int k = 0; k < NKEYS; k++) begin
				burst_m[k] <= 7'h00;
				supen_m[k] <= 1'b0;
				ref_m[k]   <= REF_INIT;
				sig_m[k]   <= REF_INIT;
				off_m[k]   <= OFFSET_INIT;
				cz_m[k]    <= 2'h0;
				cal_m[k]   <= 5'h00;
			end
		end else if (init_go) begin
			if (setup_valid)
				dirty_r <= 1'b0;
			if (hard_r)
				en_cnt_r <= init_max;
			fr_r <= 64'h0;
			for (int k = 0; k < NKEYS; k++) begin
				if (hard_r) begin
					burst_m[k] <= (7'(k) < init_max) ? DEF_BURST : 7'h00;
					supen_m[k] <= 1'b0;
				end
				off_m[k] <= OFFSET_INIT;
				cz_m[k]  <= 2'h0;
				cal_m[k] <= FULL_CAL_BURSTS;
			end
		end else begin
			fr_r <= fr_r | fast_recal;
			if (wr_ok) begin
				burst_m[setup_key] <= setup_burst;
				supen_m[setup_key] <= setup_sup_en;
				dirty_r            <= 1'b1;
				if (wr_new_en && !wr_old_en)
					en_cnt_r <= en_cnt_r + 7'h01;
				else if (!wr_new_en && wr_old_en)
					en_cnt_r <= en_cnt_r - 7'h01;
			end
			if (recal_cmd) begin
				for (int k = 0; k < NKEYS; k++) begin
					if (recal_scope[k]) begin
						cal_m[k] <= FULL_CAL_BURSTS;
						off_m[k] <= OFFSET_INIT;
						cz_m[k]  <= 2'h0;
					end
				end
			end
			if (smp && !(recal_cmd && recal_scope[key_r])) begin
				sig_m[key_r] <= adc_data;
				if (cal_k != 5'h00) begin
					// successive approximation of the ladder code, then capacitors
					if (cal_step < CAL_OFF_STEPS) begin
						off_m[key_r][sar_bit] <= sar_keep;
						if (sar_bit != 3'h0)
							off_m[key_r][sar_bit - 3'h1] <= 1'b1;
					end else if (cal_step < CAL_CZ_STEPS) begin
						if (adc_data > ADC_CZ_HIGH && cz_m[key_r] != CZ_MAX)
							cz_m[key_r] <= cz_m[key_r] + 2'h1;
					end
					if (cal_k == 5'h01)
						ref_m[key_r] <= adc_data;
					cal_m[key_r] <= cal_k - 5'h01;
				end else if (fr_r[key_r]) begin
					ref_m[key_r] <= adc_data;
				end
			end
			// request raised in the clearing cycle survives
			if (smp && cal_k == 5'h00)
				fr_r[key_r] <= fast_recal[key_r];
		end
	end

	// ****************************************
	// reporting
	// ****************************************
	// boundary flags only report; nothing here starts a recalibration
	always_ff @(posedge clk) begin
		if (rst) begin
			status_r <= 8'h00;
			det_r    <= 64'h0;
			err_r    <= 64'h0;
			errb_r   <= 8'h00;
		end else begin
			err_r <= err_hi | err_lo | guard_fail;
			errb_r <= {4'h0, err_lo[err_query_key] | guard_fail[err_query_key],
				err_hi[err_query_key] | guard_fail[err_query_key], 2'h0};
			if (si.done)
				det_r <= det_nxt;
			status_r                <= 8'h00;
			status_r[ST_DET_BIT]    <= |det_r;
			status_r[ST_CAL_BIT]    <= |cal_any;
			status_r[ST_ERR_BIT]    <= |err_r;
			status_r[ST_NV_BIT]     <= nv_mismatch | dirty_r;
		end
	end

	assign x_drive           = bi.x_drive;
	assign y_gate            = bi.y_gate;
	assign column_mux_select = bi.mux_sel;
	assign sample_gate       = bi.gate;
	assign integ_reset       = bi.integ_rst;
	assign cancel_capacitor  = bi.cancel_cap;
	assign adc_sample        = bi.strobe;
	assign backup_copy       = bk_r;
	assign backup_restore    = rs_r;
	assign status_byte       = status_r;
	assign key_detect        = det_r;
	assign key_error         = err_r;
	assign err_byte          = errb_r;

endmodule

//--- rtl/tms_strength_sup.sv
// Purpose: walks all keys once and finds the largest deviation among enabled ones
// Assumes: dev and en follow idx in the same cycle
// Notes:   64 cycles per pass; one comparator instead of a 64-way tree

`timescale 1ns/1ps

module tms_strength_sup
	import tms_pkg::*;
(
	input  wire logic  clk,  // core clock
	input  wire logic  rst,  // sync reset
	tms_sup_if.sup     si    // walk request and result
);

	logic              busy_r;
	logic signed [8:0] max_r;

	assign si.max_dev = max_r;

	always_ff @(posedge clk) begin
		si.done <= 1'b0;
		if (rst) begin
			busy_r <= 1'b0;
			si.idx <= 6'h00;
			max_r  <= -9'sd256;
		end else if (!busy_r) begin
			if (si.start) begin
				busy_r <= 1'b1;
				si.idx <= 6'h00;
				max_r  <= -9'sd256;
			end
		end else begin
			// any enabled key anywhere counts, no adjacency map
			if (si.en && si.dev > max_r)
				max_r <= si.dev;
			si.idx <= si.idx + 6'h01;
			if (si.idx == 6'(NKEYS - 1)) begin
				busy_r  <= 1'b0;
				si.done <= 1'b1;
			end
		end
	end

endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench of the touch-matrix scan logic
// Assumes: short slot unit; all keys set to one pulse
// Notes:   full calibration is waited out, so the run is long

`timescale 1ns/1ps

`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, s); end end

module testbench;
	import tms_pkg::*;
	localparam int SCAN = 64 * 220;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        soft_reset = 1'b0;
	logic [1:0]  variant = 2'h2;
	logic        setup_valid = 1'b0;
	logic        nv_mismatch = 1'b0;
	logic        setup_wr = 1'b0;
	logic [5:0]  setup_key = 6'h00;
	logic [6:0]  setup_burst = 7'h00;
	logic        setup_sup_en = 1'b0;
	logic [2:0]  spacing_sel = 3'h7;
	logic [7:0]  det_threshold = 8'h10;
	logic        recal_cmd = 1'b0;
	logic [63:0] recal_scope = 64'h0;
	logic [63:0] fast_recal = 64'h0;
	logic [63:0] guard_fail = 64'h0;
	logic [5:0]  err_query_key = 6'h00;
	wire  [7:0]  adc_data, x_drive, y_gate, status_byte, err_byte, y_clamp;
	wire  [2:0]  column_mux_select;
	wire  [1:0]  cancel_capacitor;
	wire         sample_gate, integ_reset, adc_sample, backup_copy, backup_restore;
	wire  [63:0] key_detect, key_error;
	int          n_errors = 0;
	int          checked = 0;
	int          cyc = 0;
	int          cal_cnt = 0;

	tms_scan_top #(.BURST_UNIT(220)) dut (.clk, .rst, .soft_reset, .variant, .setup_valid,
		.nv_mismatch, .setup_wr, .setup_key, .setup_burst, .setup_sup_en, .spacing_sel,
		.det_threshold, .recal_cmd, .recal_scope, .fast_recal, .guard_fail, .adc_data,
		.err_query_key, .x_drive, .y_gate, .column_mux_select, .sample_gate, .integ_reset,
		.cancel_capacitor, .adc_sample, .backup_copy, .backup_restore, .status_byte,
		.key_detect, .key_error, .err_byte);
	tms_front_model front (.clk, .adc_sample, .sample_gate, .y_gate, .x_drive,
		.column_mux_select, .adc_data, .y_clamp);

	initial forever #25 clk = ~clk;
	always @(negedge clk) if (adc_sample === 1'b1 && status_byte[ST_CAL_BIT] === 1'b1) cal_cnt++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 600000) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic end_sim;
		if (n_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_adc;
		do @(negedge clk); while (adc_sample !== 1'b1);
	endtask
	task automatic swr(input logic [5:0] k, input logic [6:0] b, input logic s);
		setup_key = k;
		setup_burst = b;
		setup_sup_en = s;
		setup_wr = 1'b1;
		@(negedge clk);
	endtask

	task automatic t_restore;
		logic r, c;
		r = 1'b0;
		c = 1'b0;
		tick(4);
		rst = 1'b0;
		repeat (3) begin
			@(negedge clk);
			r |= backup_restore;
			c |= backup_copy;
		end
		`CHK("restore", 1'b1, r)
		`CHK("copy", 1'b0, c)
	endtask
	task automatic t_setup;
		for (int k = 0; k < 64; k++) swr(6'(k), 7'h01, k == 5 || k == 9);
		setup_wr = 1'b0;
		tick(2);
		`CHK("dirty", 1'b1, status_byte[ST_NV_BIT])
	endtask
	task automatic t_soft;
		logic c;
		wait_adc();
		spacing_sel = 3'h0;
		setup_valid = 1'b1;
		soft_reset = 1'b1;
		@(negedge clk);
		soft_reset = 1'b0;
		cal_cnt = 0;
		c = 1'b0;
		repeat (3) begin
			@(negedge clk);
			c |= backup_copy;
		end
		`CHK("copy", 1'b1, c)
		`CHK("cal flag", 1'b1, status_byte[ST_CAL_BIT])
		`CHK("dirty", 1'b0, status_byte[ST_NV_BIT])
	endtask
	task automatic t_order;
		for (int k = 0; k < 10; k++) begin
			do @(negedge clk); while (y_gate === 8'h00);
			do @(negedge clk); while (x_drive === 8'h00);
			`CHK("row", 8'h01 << k[2:0], x_drive)
			`CHK("mux", 3'(k >> 3), column_mux_select)
			`CHK("caps", 2'h0, cancel_capacitor)
			wait_adc();
			tick(2);
		end
	endtask
	task automatic t_cal;
		front.lvl[3] = 8'hC8;
		front.lvl[4] = 8'h30;
		do @(negedge clk); while (status_byte[ST_CAL_BIT] !== 1'b0);
		`CHK("cal samples", 64 * 26, cal_cnt)
	endtask
	task automatic t_bound;
		tick(SCAN);
		err_query_key = 6'h03;
		tick(2);
		`CHK("hi bit", 1'b1, err_byte[ERR_HI_BIT])
		`CHK("lo bit", 1'b0, err_byte[ERR_LO_BIT])
		`CHK("field", 1'b1, key_error[3])
		err_query_key = 6'h04;
		tick(2);
		`CHK("lo bit", 1'b1, err_byte[ERR_LO_BIT])
		`CHK("hi bit", 1'b0, err_byte[ERR_HI_BIT])
		`CHK("err flag", 1'b1, status_byte[ST_ERR_BIT])
		tick(SCAN);
		`CHK("field", 1'b1, key_error[3])
		`CHK("cal flag", 1'b0, status_byte[ST_CAL_BIT])
	endtask
	task automatic t_fast;
		front.lvl[3] = 8'h80;
		fast_recal = 64'h8;
		@(negedge clk);
		fast_recal = 64'h0;
		tick(2 * SCAN);
		`CHK("field", 1'b0, key_error[3])
		`CHK("cal flag", 1'b0, status_byte[ST_CAL_BIT])
	endtask
	task automatic t_guard;
		guard_fail = 64'h80;
		err_query_key = 6'h07;
		tick(2);
		`CHK("guard bits", 2'b11, err_byte[3:2])
		`CHK("field", 1'b1, key_error[7])
		guard_fail = 64'h0;
		nv_mismatch = 1'b1;
		tick(2);
		`CHK("nv flag", 1'b1, status_byte[ST_NV_BIT])
		nv_mismatch = 1'b0;
		tick(2);
		`CHK("nv flag", 1'b0, status_byte[ST_NV_BIT])
	endtask
	task automatic t_sup;
		front.lvl[5] = 8'h50;
		front.lvl[9] = 8'h60;
		front.lvl[12] = 8'h68;
		tick(2 * SCAN);
		`CHK("det 5", 1'b1, key_detect[5])
		`CHK("det 9", 1'b0, key_detect[9])
		`CHK("det 12", 1'b1, key_detect[12])
		`CHK("det flag", 1'b1, status_byte[ST_DET_BIT])
		front.lvl[5] = 8'h80;
		tick(2 * SCAN);
		`CHK("det 9", 1'b1, key_detect[9])
		`CHK("det 5", 1'b0, key_detect[5])
	endtask
	task automatic t_recal;
		recal_scope = 64'h1;
		recal_cmd = 1'b1;
		@(negedge clk);
		recal_cmd = 1'b0;
		tick(2);
		`CHK("cal flag", 1'b1, status_byte[ST_CAL_BIT])
	endtask

	initial begin
		t_restore();
		t_setup();
		t_soft();
		t_order();
		t_cal();
		t_bound();
		t_fast();
		t_guard();
		t_sup();
		t_recal();
		end_sim();
	end
endmodule

//--- tb/tms_front_model.sv
// Purpose: matrix front end: per-key signal level and Y clamps
// Assumes: adc_data is read while adc_sample is high
// Notes:   the bench sets levels through lvl

`timescale 1ns/1ps

module tms_front_model
	import tms_pkg::*;
(
	input  wire logic       clk,               // clock
	input  wire logic       adc_sample,        // sample pulse
	input  wire logic       sample_gate,       // charge gate
	input  wire logic [7:0] y_gate,            // column gate
	input  wire logic [7:0] x_drive,           // rows
	input  wire logic [2:0] column_mux_select, // mux select
	output logic      [7:0] adc_data,          // level seen
	output logic      [7:0] y_clamp            // clamped Y lines
);
	logic [7:0] lvl [64];
	logic [2:0] row_r;
	logic [7:0] level;

	initial for (int i = 0; i < 64; i++) lvl[i] = ADC_MID;
	always_ff @(posedge clk)
		for (int i = 0; i < 8; i++) if (sample_gate && x_drive[i]) row_r <= 3'(i);
	assign level = lvl[{column_mux_select, row_r}];
	// idle bus shows the inverse so a stale read never matches by luck
	assign adc_data = adc_sample ? level : ~level;
	assign y_clamp = sample_gate ? ~y_gate : 8'hFF;
endmodule

//--- tb/tms_scan_sva.sv
// Purpose: port-level checks of the touch-matrix scan logic
// Assumes: one clock, sync reset
// Notes:   bound into tms_scan_top

`timescale 1ns/1ps

module tms_scan_sva
	import tms_pkg::*;
(
	input wire logic        clk,               // clock
	input wire logic        rst,               // reset
	input wire logic        soft_reset,        // soft reset
	input wire logic        nv_mismatch,       // store mismatch
	input wire logic [63:0] guard_fail,        // guard faults
	input wire logic [5:0]  err_query_key,     // queried key
	input wire logic [7:0]  x_drive,           // rows
	input wire logic [7:0]  y_gate,            // columns
	input wire logic [2:0]  column_mux_select, // mux select
	input wire logic        sample_gate,       // charge gate
	input wire logic        integ_reset,       // integ reset
	input wire logic        adc_sample,        // sample pulse
	input wire logic        backup_copy,       // copy pulse
	input wire logic        backup_restore,    // restore pulse
	input wire logic [7:0]  status_byte,       // status
	input wire logic [63:0] key_error,         // error field
	input wire logic [7:0]  err_byte           // error byte
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ****************
	// pin timing
	// ****************
	col_onehot_a: assert property (y_gate != 8'h00 |->
		y_gate == (8'h01 << column_mux_select) && !integ_reset) else $error("column gate");
	dwell_gate_a: assert property ($rose(sample_gate) |-> x_drive == 8'h00
		##1 ($onehot(x_drive) && sample_gate) ##1 sample_gate [*3] ##1 !sample_gate)
		else $error("dwell window");
	settle_hold_a: assert property (adc_sample |-> integ_reset &&
		$past(x_drive, 1) == $past(x_drive, 150) ##1 !adc_sample) else $error("settle");

	// ****************
	// status and errors
	// ****************
	err_pair_a: assert property (key_error[$past(err_query_key)] ==
		(err_byte[ERR_HI_BIT] | err_byte[ERR_LO_BIT])) else $error("error field");
	guard_bits_a: assert property (guard_fail[err_query_key] |=>
		err_byte[ERR_HI_BIT] && err_byte[ERR_LO_BIT]) else $error("guard bits");
	err_status_a: assert property ($rose(|key_error) |->
		##[0:2] status_byte[ST_ERR_BIT]) else $error("error status");
	nv_status_a: assert property (nv_mismatch |->
		##[1:2] status_byte[ST_NV_BIT]) else $error("store status");
	backup_once_a: assert property (backup_copy || backup_restore |->
		!(backup_copy && backup_restore) ##1 !(backup_copy || backup_restore))
		else $error("backup pulse");
	soft_cal_a: assert property (soft_reset |->
		##[1:3] status_byte[ST_CAL_BIT]) else $error("soft recal");

	cover property (adc_sample);
	cover property (backup_restore);
	cover property ($rose(|key_error));
endmodule

bind tms_scan_top tms_scan_sva u_sva (.clk, .rst, .soft_reset, .nv_mismatch, .guard_fail,
	.err_query_key, .x_drive, .y_gate, .column_mux_select, .sample_gate, .integ_reset,
	.adc_sample, .backup_copy, .backup_restore, .status_byte, .key_error, .err_byte);
